// ==== shared/pcm_pkg.sv ====
`default_nettype none
package pcm_pkg;
    localparam int unsigned PCM_CNT_W = 15;
    localparam int unsigned PCM_DUTY_W = 10;
    localparam int unsigned PCM_PER_W = 4;
    localparam int unsigned PCM_ADDR_W = 4;
    localparam int unsigned PCM_ACC_W = 9;

    localparam logic [PCM_ADDR_W-1:0] PCM_CTRL_OFS = 4'h0;
    localparam logic [PCM_ADDR_W-1:0] PCM_STAT_OFS = 4'h4;
    localparam logic [31:0] PCM_CTRL_RST = 32'h0000_0000;

    localparam logic [PCM_CNT_W-1:0] PCM_TOP_BASE = 15'h0040;
    localparam logic [PCM_CNT_W-1:0] PCM_FIXED_WRAP = 15'h03ff;
    localparam logic [PCM_PER_W-1:0] PCM_MID_CODE = 4'h4;
    localparam logic [PCM_PER_W-1:0] PCM_LAST_CODE = 4'h8;

    // Rates in quarter-MHz units so that 3.25 MHz stays an integer.
    localparam logic [PCM_ACC_W-1:0] PCM_REF_QMHZ = 9'h1f4;
    localparam logic [PCM_ACC_W-1:0] PCM_INC_26M = 9'h068;
    localparam logic [PCM_ACC_W-1:0] PCM_INC_13M = 9'h034;
    localparam logic [PCM_ACC_W-1:0] PCM_INC_6M5 = 9'h01a;
    localparam logic [PCM_ACC_W-1:0] PCM_INC_3M25 = 9'h00d;

    typedef enum logic [1:0] {
        PCM_CLK_26M,
        PCM_CLK_13M,
        PCM_CLK_6M5,
        PCM_CLK_3M25
    } pcm_clk_sel_type;

    typedef struct packed {
        logic [8:0]      rsvd;
        pcm_clk_sel_type clock_sel;
        logic            update_strobe_bit;
        logic            gated_update_select;
        logic [9:0]      duty_input;
        logic [3:0]      period;
        logic            mode_sel;
        logic            sample_method;
        logic            duty_format_bit;
        logic            polarity;
        logic            enable;
    } pcm_ctrl_type;

    typedef struct packed {
        logic [10:0] rsvd;
        logic        extra_pending;
        logic [3:0]  extra_cycle;
        logic        pulse;
        logic [14:0] count;
    } pcm_stat_type;

    typedef struct packed {
        logic [PCM_CNT_W-1:0] top;
        logic [PCM_CNT_W-1:0] wrap;
        logic [PCM_CNT_W-1:0] compare_value;
        logic [3:0]           shifted_out;
    } pcm_calc_type;
endpackage : pcm_pkg
`default_nettype wire

// ==== hw/pcm_base_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcm_base_tick (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               run,
    input  wire pcm_pkg::pcm_clk_sel_type clock_sel,
    output logic                    tick
);
    import pcm_pkg::*;

    logic [PCM_ACC_W-1:0] acc_q;
    logic [PCM_ACC_W-1:0] inc;
    logic [PCM_ACC_W:0]   sum;

    always_comb begin
        unique case (clock_sel)
            PCM_CLK_26M:  inc = PCM_INC_26M;
            PCM_CLK_13M:  inc = PCM_INC_13M;
            PCM_CLK_6M5:  inc = PCM_INC_6M5;
            PCM_CLK_3M25: inc = PCM_INC_3M25;
        endcase
        sum = {1'b0, acc_q} + {1'b0, inc};
    end

    // A fractional divider: the ticks average the base rate exactly,
    // at the price of one reference cycle of jitter per tick.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
            tick  <= 1'b0;
        end else if (!run) begin
            acc_q <= '0;
            tick  <= 1'b0;
        end else if (sum >= {1'b0, PCM_REF_QMHZ}) begin
            acc_q <= PCM_ACC_W'(sum - {1'b0, PCM_REF_QMHZ});
            tick  <= 1'b1;
        end else begin
            acc_q <= PCM_ACC_W'(sum);
            tick  <= 1'b0;
        end
    end
endmodule : pcm_base_tick
`default_nettype wire

// ==== hw/pcm_period_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcm_period_calc (
    input  wire logic [9:0]        adjusted_duty_value,
    input  wire logic [3:0]        period,
    input  wire logic              sample_method,
    input  wire logic              gated_update_select,
    output pcm_pkg::pcm_calc_type  calc
);
    import pcm_pkg::*;

    logic [PCM_CNT_W-1:0] duty_ext;
    logic [3:0]           rshift;
    logic [3:0]           lshift;
    logic [3:0]           low_mask;

    always_comb begin
        duty_ext = {5'h00, adjusted_duty_value};
        rshift   = PCM_MID_CODE - period;
        lshift   = period - PCM_MID_CODE;
        low_mask = 4'(({1'b0, 4'h1} << rshift) - 5'h01);
        calc     = '0;
        if (period <= PCM_LAST_CODE) begin
            calc.top = (PCM_TOP_BASE << period) - 15'h0001;
        end else begin
            calc.top = PCM_FIXED_WRAP;
        end
        if (period <= PCM_MID_CODE) begin
            calc.compare_value = duty_ext >> rshift;
            calc.shifted_out   = adjusted_duty_value[3:0] & low_mask;
        end else if (period <= PCM_LAST_CODE) begin
            calc.compare_value = duty_ext << lshift;
        end else begin
            calc.compare_value = duty_ext;
        end
        // Shifted-out bits are simply lost outside the fraction method.
        if (sample_method || gated_update_select) begin
            calc.wrap        = calc.top;
            calc.shifted_out = 4'h0;
        end else begin
            calc.wrap = PCM_FIXED_WRAP;
        end
    end
endmodule : pcm_period_calc
`default_nettype wire

// ==== hw/pcm_generator.sv ====
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pcm_generator (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic [pcm_pkg::PCM_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                     reg_wdata,
    input  wire logic                            reg_wr,
    input  wire logic                            reg_rd,
    output logic      [31:0]                     reg_rdata,
    input  wire logic                            sleep_req,
    output logic                                 pwm_out
);
    import pcm_pkg::*;

    pcm_ctrl_type         ctrl_q;
    pcm_ctrl_type         wr_ctrl;
    pcm_stat_type         stat;
    pcm_calc_type         calc;
    logic [9:0]           adjusted_duty_value;
    logic [9:0]           duty_w_q;
    logic [3:0]           period_w_q;
    logic [PCM_CNT_W-1:0] cnt_q;
    logic [3:0]           extra_q;
    logic [4:0]           extra_sum;
    logic                 pend_q;
    logic                 pulse_q;
    logic                 pulse_d;
    logic                 stretch_q;
    logic                 stretch_d;
    logic                 consume;
    logic                 tick;
    logic                 run;
    logic                 run_q;
    logic                 gate_ok;
    logic                 load_now;
    logic                 at_wrap;
    logic                 top_hit;
    logic                 period_start;
    logic                 compare_hit;
    logic                 accumulate;

    // Control word; sleep wipes it just as a power loss would.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= PCM_CTRL_RST;
        end else if (sleep_req) begin
            ctrl_q <= PCM_CTRL_RST;
        end else if (reg_wr && reg_addr == PCM_CTRL_OFS) begin
            ctrl_q <= wr_ctrl;
        end
    end

    always_comb begin
        wr_ctrl      = pcm_ctrl_type'(reg_wdata);
        wr_ctrl.rsvd = '0;
    end

    assign adjusted_duty_value =
        {ctrl_q.duty_input[9] ^ ~ctrl_q.duty_format_bit, ctrl_q.duty_input[8:0]};

    // The accumulator mode is not built here; with the mode bit set
    // the channel idles at its inactive level.
    assign run = ctrl_q.enable && !ctrl_q.mode_sel;
    assign gate_ok = !ctrl_q.gated_update_select || ctrl_q.update_strobe_bit;
    assign accumulate = !ctrl_q.gated_update_select && !ctrl_q.sample_method;

    pcm_base_tick u_tick (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .run       (run),
        .clock_sel (ctrl_q.clock_sel),
        .tick      (tick)
    );

    pcm_period_calc u_calc (
        .adjusted_duty_value (duty_w_q),
        .period              (period_w_q),
        .sample_method       (ctrl_q.sample_method),
        .gated_update_select (ctrl_q.gated_update_select),
        .calc                (calc)
    );

    assign at_wrap = cnt_q == calc.wrap;
    assign top_hit = (cnt_q & calc.top) == calc.top;
    assign period_start = (cnt_q & calc.top) == '0;
    // The compare runs on the masked counter, so a frame longer than the
    // period limit still repeats the pulse once per period.
    assign compare_hit = (cnt_q & calc.top) == calc.compare_value;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run;
        end
    end

    // Working copies keep a period from changing shape midway, except with the
    // gated update selected, where they load in every cycle that the strobe bit
    // is set; the first cycle after enable still loads, so a fresh start never
    // spends a frame on the settings that stood while the channel was idle.
    always_comb begin
        if (!run || !run_q) begin
            load_now = 1'b1;
        end else if (ctrl_q.gated_update_select) begin
            load_now = ctrl_q.update_strobe_bit;
        end else begin
            load_now = tick && at_wrap;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            duty_w_q   <= '0;
            period_w_q <= '0;
        end else if (load_now) begin
            duty_w_q   <= adjusted_duty_value;
            period_w_q <= ctrl_q.period;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (tick && gate_ok) begin
            if (at_wrap) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 15'h0001;
            end
        end
    end

    assign extra_sum = {1'b0, extra_q} + {1'b0, calc.shifted_out};

    // A carry arriving as a pending extra cycle is consumed keeps it.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            extra_q <= '0;
            pend_q  <= 1'b0;
        end else if (!run || !accumulate) begin
            extra_q <= '0;
            pend_q  <= 1'b0;
        end else if (tick && top_hit) begin
            extra_q <= extra_sum[3:0];
            pend_q  <= extra_sum[4] || (pend_q && !consume);
        end else if (consume) begin
            pend_q <= 1'b0;
        end
    end

    // Clear wins over set, so a zero compare value gives no pulse;
    // a pending carry stretches the pulse by one base cycle instead.
    always_comb begin
        pulse_d   = pulse_q;
        stretch_d = stretch_q;
        consume   = 1'b0;
        if (!run || !gate_ok) begin
            pulse_d   = 1'b0;
            stretch_d = 1'b0;
        end else if (tick) begin
            if (compare_hit && pend_q) begin
                pulse_d   = 1'b1;
                stretch_d = 1'b1;
                consume   = 1'b1;
            end else if (compare_hit || stretch_q) begin
                pulse_d   = 1'b0;
                stretch_d = 1'b0;
            end else if (period_start) begin
                pulse_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_q   <= 1'b0;
            stretch_q <= 1'b0;
            pwm_out   <= 1'b0;
        end else begin
            pulse_q   <= pulse_d;
            stretch_q <= stretch_d;
            pwm_out   <= pulse_d ^ ctrl_q.polarity;
        end
    end

    always_comb begin
        stat               = '0;
        stat.extra_pending = pend_q;
        stat.extra_cycle   = extra_q;
        stat.pulse         = pulse_q;
        stat.count         = cnt_q;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd && reg_addr == PCM_CTRL_OFS) begin
            reg_rdata <= ctrl_q;
        end else if (reg_rd && reg_addr == PCM_STAT_OFS) begin
            reg_rdata <= stat;
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_reset_config_zero: assert property (
        $fell(rst) |-> ctrl_q == PCM_CTRL_RST && pwm_out == 1'b0 && cnt_q == '0)
        else $error("configuration not zero after reset");

    chk_count_step: assert property (
        run && tick && gate_ok && !at_wrap |=> cnt_q == $past(cnt_q) + 15'h0001)
        else $error("counter did not step on base tick");

    chk_count_wrap: assert property (
        run && tick && gate_ok && at_wrap |=> cnt_q == '0)
        else $error("counter did not return to zero at wrap");

    chk_pulse_set: assert property (
        run && gate_ok && tick && period_start && !compare_hit && !stretch_q
        |=> pulse_q && pwm_out != $past(ctrl_q.polarity))
        else $error("output not set at period start");

    chk_pulse_clear: assert property (
        run && gate_ok && tick && compare_hit && !pend_q |=> !pulse_q)
        else $error("output not cleared at compare match");

    chk_extra_stretch: assert property (
        run && gate_ok && tick && compare_hit && pend_q |=> pulse_q && stretch_q)
        else $error("extra cycle not inserted");

    chk_stretch_end: assert property (
        run && gate_ok && tick && stretch_q && !compare_hit |=> !pulse_q && !stretch_q)
        else $error("extra cycle lasted more than one base cycle");

    chk_gate_quiet: assert property (
        run && !gate_ok |=> !pulse_q && cnt_q == $past(cnt_q))
        else $error("output or counter moved without update strobe");

    chk_disable_idle: assert property (
        !run ##1 !run |-> cnt_q == '0 && pwm_out == $past(ctrl_q.polarity))
        else $error("disabled channel not idle");

    chk_sleep_clears: assert property (
        sleep_req |=> ctrl_q == PCM_CTRL_RST ##1 pwm_out == 1'b0)
        else $error("sleep did not clear configuration");

    chk_mode_two_quiet: assert property (
        ctrl_q.mode_sel |=> !pulse_q)
        else $error("mode-one logic active with mode bit set");

    chk_top_shape: assert property (
        calc.top >= 15'h003f && calc.top <= 15'h3fff
        && (calc.top & (calc.top + 15'h0001)) == '0)
        else $error("period limit is not a run of ones");

    chk_top_others: assert property (
        period_w_q > PCM_LAST_CODE |-> calc.top == PCM_FIXED_WRAP)
        else $error("period limit wrong for codes above eight");

    chk_wrap_fixed: assert property (
        !ctrl_q.sample_method && !ctrl_q.gated_update_select |-> calc.wrap == PCM_FIXED_WRAP)
        else $error("wrap limit not fixed in fraction method");

    chk_wrap_top: assert property (
        ctrl_q.sample_method || ctrl_q.gated_update_select |-> calc.wrap == calc.top)
        else $error("wrap limit differs from period limit");

    chk_duty_adjust: assert property (
        adjusted_duty_value[8:0] == ctrl_q.duty_input[8:0]
        && adjusted_duty_value[9] == (ctrl_q.duty_input[9] == ctrl_q.duty_format_bit))
        else $error("adjusted duty value wrong");

    chk_hold_between: assert property (
        run && run_q && !ctrl_q.gated_update_select && !(tick && at_wrap)
        |=> $stable(duty_w_q) && $stable(period_w_q))
        else $error("working settings changed away from the wrap limit");

    cov_wrap: cover property (run && tick && at_wrap && cnt_q != '0);
    cov_extra_cycle: cover property (consume);
    cov_gated_pulse: cover property (ctrl_q.gated_update_select && pulse_q);
    cov_inverted_pulse: cover property (ctrl_q.polarity && pulse_q);
    cov_long_period: cover property (run && tick && at_wrap && period_w_q > PCM_LAST_CODE);
endmodule : pcm_generator
`default_nettype wire

// ==== tb/pcm_load_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stands in for the filter that the pulse drives and times each pulse in ref_clk cycles.
module pcm_load_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic level,
    output var  int   period_cyc,
    output var  int   high_cyc,
    output var  int   rises
);
    logic prev_q;
    int   since_q;
    int   hi_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
            since_q <= 0;
            hi_q <= 0;
            period_cyc <= 0;
            high_cyc <= 0;
            rises <= 0;
        end else begin
            prev_q <= level;
            since_q <= since_q + 1;
            hi_q <= hi_q + 1;
            if (level && !prev_q) begin
                period_cyc <= since_q;
                since_q <= 1;
                hi_q <= 1;
                rises <= rises + 1;
            end
            if (!level && prev_q) begin
                high_cyc <= hi_q;
            end
        end
    end
endmodule : pcm_load_model
`default_nettype wire

// ==== tb/pcm_generator_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcm_generator_test;
    import pcm_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        sleep_req = 1'b0;
    logic        pwm_out;
    int          per_c;
    int          hi_c;
    int          rises;
    int          err_count = 0;
    int          checks = 0;
    logic [31:0] rv;

    always #4 ref_clk = ~ref_clk;

    pcm_generator dut (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .reg_addr (reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr   (reg_wr),
        .reg_rd   (reg_rd),
        .reg_rdata(reg_rdata),
        .sleep_req(sleep_req),
        .pwm_out  (pwm_out)
    );

    // The pin crossbar is taken as routed to the pulse option, so the load sees pwm_out.
    pcm_load_model load (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .level     (pwm_out),
        .period_cyc(per_c),
        .high_cyc  (hi_c),
        .rises     (rises)
    );

    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : cmp

    // Base ticks come from a fractional divider, so one cycle of jitter is allowed.
    task automatic near(input int got, input int ticks, input int inc);
        int exp;
        exp = ticks * 500 / inc;
        checks++;
        if (got < exp - 1 || got > exp + 1) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : near

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    function automatic logic [31:0] cw(input logic [1:0] cs, input logic [1:0] gs,
                                       input logic [9:0] d, input logic [3:0] p,
                                       input logic [4:0] lo);
        return {9'h0, cs, gs, d, p, lo};
    endfunction : cw

    task automatic wait_rises(input int n);
        int r0;
        int k;
        r0 = rises;
        k = 0;
        while (rises < r0 + n && k < 40000) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 40000) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, rises - r0, n);
            err_count++;
        end
    endtask : wait_rises

    task automatic t_wave(input logic [31:0] w, input int top, input int hi, input int inc);
        wr(PCM_CTRL_OFS, w);
        wait_rises(3);
        near(per_c, top + 1, inc);
        near(hi_c, hi, inc);
        wr(PCM_CTRL_OFS, 32'h0);
        repeat (4) @(posedge ref_clk);
    endtask : t_wave

    // A setting that must never produce a pulse: no rise and the idle level held.
    // The idle level settles first, so the step to it is not taken for a pulse.
    task automatic t_quiet(input logic [31:0] w, input logic idle, input logic [14:0] lim);
        int r0;
        wr(PCM_CTRL_OFS, w);
        repeat (4) @(posedge ref_clk);
        r0 = rises;
        repeat (700) @(posedge ref_clk);
        cmp(32'(rises - r0), 32'h0);
        cmp({31'h0, pwm_out}, {31'h0, idle});
        rd(PCM_STAT_OFS, rv);
        cmp({31'h0, (rv[14:0] <= lim)}, 32'h1);
        wr(PCM_CTRL_OFS, 32'h0);
    endtask : t_quiet

    task automatic t_regs();
        rd(PCM_CTRL_OFS, rv);
        cmp(rv, 32'h0);
        rd(PCM_STAT_OFS, rv);
        cmp(rv, 32'h0);
        cmp({31'h0, pwm_out}, 32'h0);
        wr(PCM_CTRL_OFS, 32'hffff_ffff);
        rd(PCM_CTRL_OFS, rv);
        cmp(rv, 32'h007f_ffff);
        rd(4'h8, rv);
        cmp(rv, 32'h0);
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sleep_req <= 1'b0;
        rd(PCM_CTRL_OFS, rv);
        cmp(rv, 32'h0);
        cmp({31'h0, pwm_out}, 32'h0);
    endtask : t_regs

    initial begin
        repeat (3) @(posedge ref_clk);
        // The clock already runs when reset is released, before any write.
        rst <= 1'b0;
        t_regs();
        t_wave(cw(2'd0, 2'b00, 10'h200, 4'h0, 5'h0d), 63, 32, 104);
        t_wave(cw(2'd0, 2'b00, 10'h100, 4'h0, 5'h0f), 63, 48, 104);
        t_wave(cw(2'd0, 2'b00, 10'h300, 4'h0, 5'h09), 63, 16, 104);
        t_wave(cw(2'd1, 2'b00, 10'h200, 4'h1, 5'h0d), 127, 64, 52);
        t_wave(cw(2'd2, 2'b00, 10'h200, 4'h0, 5'h0d), 63, 32, 26);
        t_wave(cw(2'd3, 2'b00, 10'h200, 4'h0, 5'h0d), 63, 32, 13);
        t_wave(cw(2'd0, 2'b00, 10'h200, 4'h9, 5'h0d), 1023, 512, 104);
        t_wave(cw(2'd0, 2'b00, 10'h010, 4'h5, 5'h0d), 2047, 32, 104);
        t_wave(cw(2'd0, 2'b11, 10'h200, 4'h0, 5'h05), 63, 32, 104);
        t_wave(cw(2'd0, 2'b00, 10'h008, 4'h0, 5'h05), 127, 1, 104);
        t_quiet(cw(2'd0, 2'b01, 10'h200, 4'h0, 5'h05), 1'b0, 15'h0000);
        t_quiet(cw(2'd0, 2'b11, 10'h00f, 4'h0, 5'h05), 1'b0, 15'h003f);
        t_quiet(cw(2'd0, 2'b00, 10'h200, 4'h0, 5'h13), 1'b1, 15'h0000);
        t_quiet(cw(2'd0, 2'b00, 10'h200, 4'h0, 5'h02), 1'b1, 15'h0000);
        final_report();
    end

    // The longest wave case needs about 20000 cycles; the whole run stays well below this.
    initial begin
        repeat (95000) @(posedge ref_clk);
        err_count++;
        final_report();
    end
endmodule : pcm_generator_test
`default_nettype wire
